/* File: src/dual_conv_pkg.sv */
// Operation
// [R01] Low strap, high reference pin: internal, stabilizer on
// [R02] High strap: external reference, stabilizer on
// [R03] Mid strap: stabilizer off, reference follows pin
// [R04] Stabilizer tolerates 30 to 70 percent duty
// [R05] Mid format strap: strobe on B, A selects format
// [R06] Format strap low offset binary, high two's complement
// [R07] Strobe mode: A pin low offset, high two's
// [R08] Normal mode: enable pin low drives, high floats
// [R09] Power-down: low power, outputs undefined, pipeline lost
// [R10] Capture side waits for recovery after power-down
// [R11] Two 12-bit buses, valid while enabled and powered
// [R12] Formats differ only in inverted top bit
// [R13] Far side supplies continuous 10 to 80 MHz clock; testbench drives a 4 ns (250 MHz) clock
// [R14] Straps three-level, applied only between conversions
package dual_conv_pkg;

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  localparam int              SAMPLE_W  = 12;
  localparam logic [11:0]     MSB_FLIP  = 12'h800;   // Top bit only
  localparam int              COUNT_W   = 16;

  // Three-level strap reading from the pad comparators
  typedef enum logic [1:0] {
    LVL_LOW  = 2'b00,
    LVL_MID  = 2'b01,
    LVL_HIGH = 2'b10
  } level_e;

  // Decoded static mode
  typedef struct packed {
    logic ref_internal;
    logic dcs_on;
    logic strobe_mode;
    logic twos_comp;
  } mode_s;

  localparam mode_s MODE_RESET = 4'hc;   // Internal ref, stabilizer on, enables, offset

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int              ADDR_W       = 8;
  localparam logic [7:0]      OFF_CONTROL  = 8'h00;
  localparam logic [7:0]      OFF_STATUS   = 8'h04;
  localparam logic [7:0]      OFF_COUNT    = 8'h08;
  localparam logic [1:0]      CONTROL_RESET = 2'h0;
  localparam int              CTRL_SOFT_PD  = 0;
  localparam int              CTRL_HOLD     = 1;
  localparam int              ST_MODE_LSB   = 0;
  localparam int              ST_PD         = 4;
  localparam int              ST_OE_A       = 5;
  localparam int              ST_OE_B       = 6;

endpackage : dual_conv_pkg

/* File: src/chan_out_stage.sv */
`timescale 1ns/1ps
// One channel's output register: format conversion, enable and power-down
module chan_out_stage (
  input  wire logic                               clk,         // Sample clock
  input  wire logic                               arst_n,      // Async reset, active low
  input  wire logic [dual_conv_pkg::SAMPLE_W-1:0] sample,      // Offset-binary core result
  input  wire logic                               sample_vld,  // Core result strobe
  input  wire logic                               twos_comp,   // Format select
  input  wire logic                               enable,      // Drive the bus
  input  wire logic                               power_down,  // Low-power state
  output logic      [dual_conv_pkg::SAMPLE_W-1:0] data_r,      // Registered output word
  output logic      [dual_conv_pkg::SAMPLE_W-1:0] oe_r         // Per-bit drive enable
);

  logic [dual_conv_pkg::SAMPLE_W-1:0] data_nxt;
  logic [dual_conv_pkg::SAMPLE_W-1:0] oe_nxt;

  // ----------------------------------------------------------------
  // Next word
  // ----------------------------------------------------------------
  // Power-down flushes the held word so no stale sample survives it
  always_comb begin
    data_nxt = data_r;
    oe_nxt   = {dual_conv_pkg::SAMPLE_W{enable}};              // R08 R11
    if (power_down) begin
      data_nxt = '0;                                           // R09
    end else if (sample_vld) begin
      data_nxt = twos_comp ? (sample ^ dual_conv_pkg::MSB_FLIP) : sample;  // R12
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_r <= '0;
      oe_r   <= '0;
    end else begin
      data_r <= data_nxt;
      oe_r   <= oe_nxt;
    end
  end

endmodule : chan_out_stage

/* File: src/dual_conv_ctrl.sv */
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Mode decode and output control for the dual converter
module dual_conv_ctrl (
  input  wire logic                               CLOCK,          // Sample clock, 4 ns
  input  wire logic                               ARST_N,         // Async reset, active low
  // APB slave
  input  wire logic                               PSEL,           // Slave select
  input  wire logic                               PENABLE,        // Access phase
  input  wire logic                               PWRITE,         // Write when high
  input  wire logic [dual_conv_pkg::ADDR_W-1:0]   PADDR,          // Byte address
  input  wire logic [31:0]                        PWDATA,         // Write data
  output logic      [31:0]                        PRDATA,         // Read data
  output logic                                    PREADY,         // Transfer done
  output logic                                    PSLVERR,        // Unmapped address
  // Straps and pins
  input  wire logic [1:0]                         REF_STAB_STRAP, // Reference/stabilizer strap level
  input  wire logic                               REF_PIN_HIGH,   // Reference pin at logic high
  input  wire logic [1:0]                         FMT_STRB_STRAP, // Format/strobe strap level
  input  wire logic                               CHAN_A_PIN,     // Enable A or format select
  input  wire logic                               CHAN_B_PIN_I,   // Enable B when an input
  output logic                                    CHAN_B_PIN_O,   // Data-ready strobe
  output logic                                    CHAN_B_PIN_OE,  // High while driving strobe
  input  wire logic                               POWER_DOWN_PIN, // Power-down, active high
  // Conversion core
  input  wire logic [dual_conv_pkg::SAMPLE_W-1:0] CORE_A,         // Channel A, offset binary
  input  wire logic [dual_conv_pkg::SAMPLE_W-1:0] CORE_B,         // Channel B, offset binary
  input  wire logic                               CORE_VALID,     // New conversion pair
  output logic                                    REF_INTERNAL,   // Internal reference chosen
  output logic                                    DCS_ENABLE,     // Stabilizer running
  output logic                                    LOW_POWER,      // Analog blocks powered off
  // Data buses
  output logic      [dual_conv_pkg::SAMPLE_W-1:0] DATA_A,         // Channel A word
  output logic      [dual_conv_pkg::SAMPLE_W-1:0] DATA_A_OE,      // Channel A drive enables
  output logic      [dual_conv_pkg::SAMPLE_W-1:0] DATA_B,         // Channel B word
  output logic      [dual_conv_pkg::SAMPLE_W-1:0] DATA_B_OE       // Channel B drive enables
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dual_conv_pkg::mode_s                mode_r, mode_nxt, strap_mode;
  logic [1:0]                          control_r, control_nxt;
  logic [dual_conv_pkg::COUNT_W-1:0]   count_r, count_nxt;
  logic                                pd_r, pd_nxt;
  logic                                strobe_r, strobe_nxt;
  logic                                strobe_oe_r, strobe_oe_nxt;
  logic                                ref_int_r, dcs_r;
  logic [31:0]                         prdata_r, prdata_nxt;
  logic                                pready_r, pready_nxt;
  logic                                pslverr_r, pslverr_nxt;
  logic                                en_a, en_b;
  logic                                fmt_twos;
  logic                                wr_take;
  logic                                addr_ok;
  logic                                pd_now;

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  // An unused comparator code is read as low, the safest default
  always_comb begin
    strap_mode = dual_conv_pkg::MODE_RESET;
    case (dual_conv_pkg::level_e'(REF_STAB_STRAP))                 // R14
      dual_conv_pkg::LVL_LOW: begin
        strap_mode.ref_internal = REF_PIN_HIGH;                    // R01
        strap_mode.dcs_on       = 1'b1;                            // R01
      end
      dual_conv_pkg::LVL_HIGH: begin
        strap_mode.ref_internal = 1'b0;                            // R02
        strap_mode.dcs_on       = 1'b1;                            // R02
      end
      dual_conv_pkg::LVL_MID: begin
        strap_mode.ref_internal = REF_PIN_HIGH;                    // R03
        strap_mode.dcs_on       = 1'b0;                            // R03
      end
      default: begin
        strap_mode.ref_internal = REF_PIN_HIGH;
        strap_mode.dcs_on       = 1'b1;
      end
    endcase
    case (dual_conv_pkg::level_e'(FMT_STRB_STRAP))                 // R14
      dual_conv_pkg::LVL_MID: begin
        strap_mode.strobe_mode = 1'b1;                             // R05
        strap_mode.twos_comp   = 1'b0;
      end
      dual_conv_pkg::LVL_HIGH: begin
        strap_mode.strobe_mode = 1'b0;
        strap_mode.twos_comp   = 1'b1;                             // R06
      end
      default: begin
        strap_mode.strobe_mode = 1'b0;
        strap_mode.twos_comp   = 1'b0;                             // R06
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Mode and power state
  // ----------------------------------------------------------------
  // Straps are static, so they are only picked up at a conversion
  // boundary; a change mid-conversion would mix formats in one pair
  always_comb begin
    pd_now   = POWER_DOWN_PIN | control_r[dual_conv_pkg::CTRL_SOFT_PD];
    pd_nxt   = pd_now;                                             // R09
    mode_nxt = mode_r;
    if (CORE_VALID && !control_r[dual_conv_pkg::CTRL_HOLD]) begin
      mode_nxt = strap_mode;                                       // R14
    end
  end

  // Format and enables from the latched mode and live pins
  always_comb begin
    if (mode_r.strobe_mode) begin
      fmt_twos = CHAN_A_PIN;                                       // R07
      en_a     = 1'b1;                                             // R05
      en_b     = 1'b1;
    end else begin
      fmt_twos = mode_r.twos_comp;                                 // R06
      en_a     = !CHAN_A_PIN;                                      // R08
      en_b     = !CHAN_B_PIN_I;                                    // R08
    end
  end

  // Strobe marks the cycle a fresh pair appears on the buses
  always_comb begin
    strobe_oe_nxt = mode_r.strobe_mode;                            // R05
    strobe_nxt    = mode_r.strobe_mode & CORE_VALID & !pd_now;     // R05 R09
  end

  // Sample counter restarts on every power-down so software can
  // judge how long the buses have carried live data after wake-up
  always_comb begin
    count_nxt = count_r;
    if (pd_now) begin
      count_nxt = '0;                                              // R09
    end else if (CORE_VALID && count_r != '1) begin
      count_nxt = count_r + 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_r      <= dual_conv_pkg::MODE_RESET;
      pd_r        <= 1'b0;
      strobe_r    <= 1'b0;
      strobe_oe_r <= 1'b0;
      count_r     <= '0;
      ref_int_r   <= 1'b1;
      dcs_r       <= 1'b1;
    end else begin
      mode_r      <= mode_nxt;
      pd_r        <= pd_nxt;
      strobe_r    <= strobe_nxt;
      strobe_oe_r <= strobe_oe_nxt;
      count_r     <= count_nxt;
      ref_int_r   <= mode_nxt.ref_internal;                        // R01 R02 R03
      dcs_r       <= mode_nxt.dcs_on & !pd_now;                    // R04
    end
  end

  // ----------------------------------------------------------------
  // Output stages
  // ----------------------------------------------------------------
  chan_out_stage u_chan_a (
    .clk        (CLOCK),
    .arst_n     (ARST_N),
    .sample     (CORE_A),
    .sample_vld (CORE_VALID),
    .twos_comp  (fmt_twos),
    .enable     (en_a),
    .power_down (pd_now),
    .data_r     (DATA_A),                                          // R11
    .oe_r       (DATA_A_OE)
  );

  chan_out_stage u_chan_b (
    .clk        (CLOCK),
    .arst_n     (ARST_N),
    .sample     (CORE_B),
    .sample_vld (CORE_VALID),
    .twos_comp  (fmt_twos),
    .enable     (en_b),
    .power_down (pd_now),
    .data_r     (DATA_B),                                          // R11
    .oe_r       (DATA_B_OE)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read data is registered during setup, so every transfer completes
  // in its first access cycle without a combinational output path
  always_comb begin
    addr_ok = (PADDR == dual_conv_pkg::OFF_CONTROL) ||
              (PADDR == dual_conv_pkg::OFF_STATUS)  ||
              (PADDR == dual_conv_pkg::OFF_COUNT);
    wr_take     = PSEL & PENABLE & pready_r & PWRITE;
    pready_nxt  = PSEL & !PENABLE;
    pslverr_nxt = PSEL & !PENABLE & !addr_ok;
    prdata_nxt  = '0;
    if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        dual_conv_pkg::OFF_CONTROL: prdata_nxt[1:0] = control_r;
        dual_conv_pkg::OFF_STATUS: begin
          prdata_nxt[dual_conv_pkg::ST_MODE_LSB +: 4] = mode_r;
          prdata_nxt[dual_conv_pkg::ST_PD]            = pd_r;
          prdata_nxt[dual_conv_pkg::ST_OE_A]          = DATA_A_OE[0];
          prdata_nxt[dual_conv_pkg::ST_OE_B]          = DATA_B_OE[0];
        end
        dual_conv_pkg::OFF_COUNT: prdata_nxt[dual_conv_pkg::COUNT_W-1:0] = count_r;
        default: prdata_nxt = '0;
      endcase
    end
    control_nxt = control_r;
    if (wr_take && PADDR == dual_conv_pkg::OFF_CONTROL) begin
      control_nxt = PWDATA[1:0];
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      control_r <= dual_conv_pkg::CONTROL_RESET;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      control_r <= control_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Port drive
  // ----------------------------------------------------------------
  assign PRDATA        = prdata_r;
  assign PREADY        = pready_r;
  assign PSLVERR       = pslverr_r;
  assign CHAN_B_PIN_O  = strobe_r;
  assign CHAN_B_PIN_OE = strobe_oe_r;
  assign REF_INTERNAL  = ref_int_r;
  assign DCS_ENABLE    = dcs_r;
  assign LOW_POWER     = pd_r;

endmodule : dual_conv_ctrl

/* File: sim/dual_conv_checker.sv */
`timescale 1ns/1ps
// Watches the output side of the converter control block
module dual_conv_checker (
  input wire logic                               CLOCK,          // Sample clock
  input wire logic                               ARST_N,         // Async reset, active low
  input wire logic                               CHAN_A_PIN,     // Enable A or format
  input wire logic                               CHAN_B_PIN_I,   // Enable B
  input wire logic                               CHAN_B_PIN_O,   // Data-ready strobe
  input wire logic                               CHAN_B_PIN_OE,  // Strobe mode
  input wire logic                               POWER_DOWN_PIN, // Power-down
  input wire logic                               CORE_VALID,     // New pair
  input wire logic                               DCS_ENABLE,     // Stabilizer running
  input wire logic                               LOW_POWER,      // Power-down state
  input wire logic [dual_conv_pkg::SAMPLE_W-1:0] DATA_A,         // Channel A word
  input wire logic [dual_conv_pkg::SAMPLE_W-1:0] DATA_A_OE,      // Channel A enables
  input wire logic [dual_conv_pkg::SAMPLE_W-1:0] DATA_B,         // Channel B word
  input wire logic [dual_conv_pkg::SAMPLE_W-1:0] DATA_B_OE       // Channel B enables
);
  // ------------------------------------------------------------
  // Warm-up counter and properties
  // ------------------------------------------------------------
  logic [1:0] warm_r;
  logic [1:0] warm_nxt;
  // Past values seen during reset must not feed a check
  always_comb begin
    warm_nxt = (warm_r == 2'h3) ? warm_r : warm_r + 2'h1;
  end
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) warm_r <= 2'h0;
    else warm_r <= warm_nxt;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  sequence pd_held_s; LOW_POWER [*3]; endsequence
  sequence norm_held_s; (!CHAN_B_PIN_OE && warm_r == 2'h3) [*3]; endsequence
  AST_STROBE_ONLY_DRIVEN: assert property (CHAN_B_PIN_O |-> CHAN_B_PIN_OE)
    else $error("strobe high while pin not driven");
  AST_STROBE_CAUSE: assert property (CHAN_B_PIN_O |-> $past(CORE_VALID))
    else $error("strobe without a new pair");
  AST_STROBE_BUSES_ON: assert property ((CHAN_B_PIN_OE && warm_r == 2'h3) [*3] |-> &DATA_A_OE && &DATA_B_OE)
    else $error("bus released in strobe mode");
  AST_ENABLE_A: assert property (norm_held_s |-> DATA_A_OE == {12{!$past(CHAN_A_PIN)}})
    else $error("channel A enable wrong");
  AST_ENABLE_B: assert property (norm_held_s |-> DATA_B_OE == {12{!$past(CHAN_B_PIN_I)}})
    else $error("channel B enable wrong");
  AST_PD_ENTER: assert property (POWER_DOWN_PIN [*2] |=> LOW_POWER)
    else $error("power-down not entered");
  AST_PD_DATA: assert property (pd_held_s |-> DATA_A == 12'h000 && DATA_B == 12'h000)
    else $error("data moving in power-down");
  AST_PD_NO_STROBE: assert property (pd_held_s |-> !CHAN_B_PIN_O)
    else $error("strobe in power-down");
  AST_PD_DCS_OFF: assert property (pd_held_s |-> !DCS_ENABLE)
    else $error("stabilizer on in power-down");
endmodule : dual_conv_checker

bind dual_conv_ctrl dual_conv_checker dual_conv_checker_inst (.CLOCK, .ARST_N, .CHAN_A_PIN, .CHAN_B_PIN_I,
  .CHAN_B_PIN_O, .CHAN_B_PIN_OE, .POWER_DOWN_PIN, .CORE_VALID, .DCS_ENABLE, .LOW_POWER, .DATA_A, .DATA_A_OE,
  .DATA_B, .DATA_B_OE);

/* File: sim/capture_model.sv */
`timescale 1ns/1ps
// Capture logic that latches both sample words on the data-ready strobe
module capture_model #(
  parameter int RECOVER = 4  // Cycles ignored after power-down
) (
  input  wire logic        clk,       // Sample clock
  input  wire logic        strobe,    // Data-ready strobe
  input  wire logic        strobe_oe, // Strobe pin driven
  input  wire logic        pd,        // Power-down request
  input  wire logic [11:0] bus_a,     // Resolved channel A bus
  input  wire logic [11:0] bus_b,     // Resolved channel B bus
  output logic      [11:0] got_a,     // Last captured A
  output logic      [11:0] got_b,     // Last captured B
  output int               n_strobe   // Captures taken
);
  int settle = 0;
  initial n_strobe = 0;
  // Words after power-down are not trusted until the bypass caps recharge
  always @(posedge clk) begin
    if (pd) settle <= RECOVER;
    else if (settle != 0) settle <= settle - 1;
    if (strobe_oe && strobe && settle == 0 && !pd) begin
      got_a    <= bus_a;
      got_b    <= bus_b;
      n_strobe <= n_strobe + 1;
    end
  end
endmodule : capture_model

/* File: sim/dual_conv_ctrl_tb.sv */
`timescale 1ns/1ps
module dual_conv_ctrl_tb;
  // ------------------------------------------------------------
  // Stimulus, model and checks
  // ------------------------------------------------------------
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, ref_pin = 1'b1, a_pin = 1'b0, b_drv = 1'b0, b_pin_o, b_pin_oe;
  logic        pd_pin = 1'b0, core_valid = 1'b0, ref_int, dcs_en, low_pow;
  logic [1:0]  ref_strap = 2'h0, fmt_strap = 2'h0;
  logic [11:0] core_a = 12'h000, core_b = 12'h000, data_a, data_a_oe, data_b, data_b_oe, got_a, got_b;
  int          num_errors = 0, n_tests = 0, n_strobe, s0;
  // Released pins show the inverse of their last value
  wire [11:0] bus_a   = data_a ^ ~data_a_oe;
  wire [11:0] bus_b   = data_b ^ ~data_b_oe;
  wire        b_pin_i = b_pin_oe ? b_pin_o : b_drv;
  always #2 clk = ~clk;
  dual_conv_ctrl dual_conv_ctrl_inst (.CLOCK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .REF_STAB_STRAP(ref_strap), .REF_PIN_HIGH(ref_pin), .FMT_STRB_STRAP(fmt_strap), .CHAN_A_PIN(a_pin),
    .CHAN_B_PIN_I(b_pin_i), .CHAN_B_PIN_O(b_pin_o), .CHAN_B_PIN_OE(b_pin_oe), .POWER_DOWN_PIN(pd_pin),
    .CORE_A(core_a), .CORE_B(core_b), .CORE_VALID(core_valid), .REF_INTERNAL(ref_int), .DCS_ENABLE(dcs_en),
    .LOW_POWER(low_pow), .DATA_A(data_a), .DATA_A_OE(data_a_oe), .DATA_B(data_b), .DATA_B_OE(data_b_oe));
  capture_model capture_model_inst (.clk(clk), .strobe(b_pin_o), .strobe_oe(b_pin_oe), .pd(low_pow),
    .bus_a(bus_a), .bus_b(bus_b), .got_a(got_a), .got_b(got_b), .n_strobe(n_strobe));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // APB transfer; the request is held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, addr, wdata};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    check("pready", n < 50, 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Two conversions so the latched mode reaches the data, then settle
  task automatic conv2(input logic [11:0] a, input logic [11:0] b);
    repeat (2) begin
      @(posedge clk);
      {core_valid, core_a, core_b} <= {1'b1, a, b};
      @(posedge clk);
      core_valid <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask : conv2
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    #40000;
    num_errors++;
    finish_test();
  end
  // Reference table: strap; then bits pin, internal, stabilizer
  logic [1:0] rs [4] = '{2'h0, 2'h2, 2'h1, 2'h1};
  logic [2:0] rx [4] = '{3'b111, 3'b001, 3'b110, 3'b000};
  // Format table: strap, A pin, B pin, two's, A on, B on, strobe
  logic [1:0] fs [6] = '{2'h0, 2'h2, 2'h0, 2'h2, 2'h1, 2'h1};
  logic [5:0] fx [6] = '{6'b000110, 6'b001110, 6'b100010, 6'b011100, 6'b010111, 6'b101111};
  logic [11:0] a, b;
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    check("ref_reset", ref_int, 1'b1);
    apb(1'b0, 8'h00, 32'h0);
    check("control_reset", rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      ref_strap <= rs[i];
      ref_pin   <= rx[i][2];
      conv2(12'h123, 12'h456);
      check("ref_internal", ref_int, rx[i][1]);
      check("dcs", dcs_en, rx[i][0]);
      apb(1'b0, 8'h04, 32'h0);
      check("status_mode", rd[6:0], {3'b110, rx[i][1:0], 2'b00});
    end
    $display("test reference done");
    for (int i = 0; i < 6; i++) begin
      a = 12'h800 + 12'(i);
      b = 12'h7f0 - 12'(i);
      {fmt_strap, a_pin, b_drv} <= {fs[i], fx[i][5:4]};
      s0 = n_strobe;
      conv2(a, b);
      if (fx[i][2]) check("data_a", data_a, a ^ (fx[i][3] ? dual_conv_pkg::MSB_FLIP : 12'h000));
      if (fx[i][1]) check("data_b", data_b, b ^ (fx[i][3] ? dual_conv_pkg::MSB_FLIP : 12'h000));
      check("oe_a", data_a_oe, {12{fx[i][2]}});
      check("oe_b", data_b_oe, {12{fx[i][1]}});
      check("strobe_oe", b_pin_oe, fx[i][0]);
      // Entering strobe mode, the first pair still goes out under the old mode
      check("strobes", n_strobe - s0, fx[i][0] ? (fs[i-1] == 2'h1 ? 2 : 1) : 0);
      if (fx[i][0]) check("got_a", got_a, a ^ (fx[i][3] ? dual_conv_pkg::MSB_FLIP : 12'h000));
      if (fx[i][0]) check("got_b", got_b, b ^ (fx[i][3] ? dual_conv_pkg::MSB_FLIP : 12'h000));
    end
    $display("test format done");
    {fmt_strap, a_pin, b_drv} <= 4'h0;
    // Internal reference first, so the hold test below sees a real change
    {ref_strap, ref_pin} <= {2'h0, 1'b1};
    pd_pin <= 1'b1;
    conv2(12'hfff, 12'hfff);
    check("pd_state", {low_pow, dcs_en, data_a}, {2'b10, 12'h000});
    pd_pin <= 1'b0;
    conv2(12'h001, 12'h002);
    check("pd_exit", {low_pow, data_a}, {1'b0, 12'h001});
    apb(1'b0, 8'h08, 32'h0);
    check("count", rd, 32'h2);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    check("soft_pd", {rd[4], low_pow}, 2'b11);
    apb(1'b1, 8'h00, 32'h2);
    {ref_strap, ref_pin} <= {2'h2, 1'b0};
    conv2(12'h000, 12'h000);
    check("hold_ref", ref_int, 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    conv2(12'h000, 12'h000);
    check("release_ref", ref_int, 1'b0);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped", {err, rd}, {1'b1, 32'h0});
    $display("test power and bus done");
    finish_test();
  end
endmodule : dual_conv_ctrl_tb
